// ==== bench/osc_model.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Oscillator stand-in; a stopped oscillator holds its last level
// ==========================================================================
module osc_model (
    // Clock
    input  wire logic       ref_clk,
    // Control
    input  wire logic       run,
    input  wire logic [3:0] half,
    // Oscillator pins
    output logic            primary_clk,
    output logic            secondary_clk
);
    logic [3:0] cnt = 4'h0;
    initial primary_clk = 1'b0;
    // Toggle every half cycles while running
    always @(posedge ref_clk) begin
        cnt <= (cnt >= half - 4'h1) ? 4'h0 : cnt + 4'h1;
        if (run && cnt == 4'h0) primary_clk <= ~primary_clk;
    end
    assign secondary_clk = ~primary_clk; // Selected only after the test stages the secondary source and enters a mode
endmodule // osc_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Bench top
// ==========================================================================
module tb_top;
    import clock_recovery_pkg::*;
    logic        ref_clk = 0, rst = 1, pm_enter = 0, wake_sleep = 0;
    logic [3:0]  half;
    logic [4:0]  avs_address = 0;
    logic        avs_read = 0, avs_write = 0, avs_waitrequest, irq, wdt_reset;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [1:0]  core_clk_sel;
    logic        primary_osc_en, primary_clock_ready_flag, pm_wake_req, p_clk, s_clk;
    int n_errors = 0, checks_done = 0, cyc = 0, n_wdt = 0, n_wake = 0, m_flag = 0;
    always #5 ref_clk = ~ref_clk;
    osc_model osc (.ref_clk(ref_clk), .run(1'b1), .half(half), .primary_clk(p_clk),
                   .secondary_clk(s_clk));
    fail_safe_clock_recovery dut (.ref_clk(ref_clk), .rst(rst), .primary_clk(p_clk),
        .secondary_clk(s_clk), .pm_enter(pm_enter), .wake_sleep(wake_sleep),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_clk_sel(core_clk_sel),
        .primary_osc_en(primary_osc_en), .primary_clock_ready_flag(primary_clock_ready_flag),
        .wdt_reset(wdt_reset), .pm_wake_req(pm_wake_req), .irq(irq));
    task end_of_test;
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One Avalon access; upper data bits are random since they are ignored
    task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d | ($urandom & 32'hffffff00);
        avs_read <= !wr;
        avs_write <= wr;
        // Held until waitrequest is seen low at a rising edge; only the hang limit ends it
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(negedge ref_clk);
    endtask
    task automatic pulse(input bit w);
        @(posedge ref_clk);
        if (w) wake_sleep <= 1;
        else pm_enter <= 1;
        @(posedge ref_clk);
        wake_sleep <= 0;
        pm_enter <= 0;
        repeat (2) @(negedge ref_clk);
    endtask
    // Bounded wait for the next failure pulse
    task automatic wait_fail;
        int n0;
        n0 = n_wdt;
        for (int i = 0; i < 400 && n_wdt == n0; i++) @(negedge ref_clk);
        check(n_wdt, n0 + 1);
        m_flag = 1;
    endtask
    // Pulse counters and hang limit
    always @(posedge ref_clk) begin
        cyc++;
        if (wdt_reset === 1'b1) n_wdt++;
        if (pm_wake_req === 1'b1) n_wake++;
        if (cyc > 60000) begin
            n_errors++;
            end_of_test;
        end
    end
    initial begin
        void'($urandom(49));
        half = 4'h2 + 4'($urandom % 3);
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        @(negedge ref_clk);
        check({primary_osc_en, core_clk_sel}, 3'h6);
        bus(0, 5'h04, 0);
        check(rd, 32'h12);
        bus(1, 5'h14, 32'hff);
        bus(0, 5'h14, 0);
        check(rd, 0);
        // Crystal start-up: no failure until the timer runs out
        for (int i = 0; i < 9000 && primary_clock_ready_flag !== 1'b1; i++) @(negedge ref_clk);
        check(n_wdt, 0);
        check({primary_clock_ready_flag, core_clk_sel}, 3'h4);
        wait_fail();
        check(core_clk_sel, 2'b10);
        bus(0, 5'h0c, 0);
        check(rd, 1);
        // Failures in a managed mode, interrupt enabled then disabled
        for (int m = 1; m >= 0; m--) begin
            bus(1, 5'h10, m);
            check(irq, m_flag & m);
            bus(1, 5'h0c, 1);
            m_flag = 0;
            bus(1, 5'h00, 0);
            pulse(0);
            check(core_clk_sel, 2'b00);
            bus(0, 5'h08, 0);
            check(rd[1], 0);
            wait_fail();
            repeat (100) @(negedge ref_clk);
            check(core_clk_sel, 2'b10);
            check(n_wake, 1);
            check(irq, m_flag & m);
        end
        bus(1, 5'h00, 1);
        pulse(0);
        check(core_clk_sel, 2'b01);
        bus(1, 5'h00, 2);
        pulse(0);
        pulse(1);
        check({primary_clock_ready_flag, core_clk_sel}, 3'h2);
        pulse(0);
        check(primary_osc_en, 0);
        bus(1, 5'h04, 32'h14);
        pulse(1);
        check(primary_clock_ready_flag, 1);
        end_of_test;
    end
endmodule // tb_top

// ==== common/clock_recovery_defs.svh ====
`ifndef CLOCK_RECOVERY_DEFS_SVH
`define CLOCK_RECOVERY_DEFS_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
// ==========================================================================
`define REG_OSC_CTRL      5'h00
`define REG_OSC_CFG       5'h04
`define REG_STATUS        5'h08
`define REG_IRQ_STAT      5'h0c
`define REG_IRQ_MASK      5'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define CTRL_SRC_LSB      0
`define CTRL_PEND_LSB     4
`define CFG_MODE_LSB      0
`define CFG_MON_EN_BIT    4
`define STAT_READY_BIT    0
`define STAT_FAILSAFE_BIT 1
`define STAT_CORE_LSB     2
`define STAT_PRIM_EN_BIT  4
`define STAT_STATE_LSB    5
`define IRQ_OSC_FAIL_BIT  0

// ==========================================================================
// Reset values
// ==========================================================================
`define CFG_MODE_RST      3'h2
`define CFG_MON_EN_RST    1'b1
`define IRQ_MASK_RST      1'b0

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS     10
`define PLL_LOCK_NS       2000
`define PLL_LOCK_CYC      ((`PLL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_EDGES         1024
`define SAMPLE_DIV        64
`define SAMPLE_HALF       (`SAMPLE_DIV / 2)

`endif

// ==== common/clock_recovery_pkg.sv ====
// ==========================================================================
// Types shared by the recovery controller and the sample monitor
// ==========================================================================
package clock_recovery_pkg;

    // Controller states
    typedef enum logic [1:0] {
        st_start    = 2'b00,
        st_primary  = 2'b01,
        st_pm       = 2'b10,
        st_failsafe = 2'b11
    } recov_state_t;

    // Core clock sources
    typedef enum logic [1:0] {
        src_primary   = 2'b00,
        src_secondary = 2'b01,
        src_internal  = 2'b10
    } clk_src_t;

    // Primary oscillator modes
    typedef enum logic [2:0] {
        low_power_crystal_mode      = 3'h0,
        standard_crystal_mode       = 3'h1,
        high_speed_crystal_mode     = 3'h2,
        high_speed_crystal_with_pll = 3'h3,
        external_clock_mode         = 3'h4,
        rc_osc_mode                 = 3'h5,
        internal_rc_mode            = 3'h6
    } osc_mode_t;

    // All controller state
    typedef struct packed {
        recov_state_t state;
        clk_src_t     osc_ctrl;
        clk_src_t     pend_src;
        osc_mode_t    prim_mode;
        logic         mon_en;
        logic         ready;
        clk_src_t     core_sel;
        logic         prim_en;
        logic [10:0]  osc_cnt;
        logic [8:0]   pll_cnt;
        logic         irq_flag;
        logic         irq_mask;
        logic         irq;
        logic         wdt_clr;
        logic         pm_wake;
        logic         clk_q;
        logic         bus_wait;
        logic [31:0]  rdata;
    } recov_regs_t;

    // Sample monitor state
    typedef struct packed {
        logic [5:0] div;
        logic       latch;
        logic       fail;
    } monitor_regs_t;

endpackage

// ==== rtl/fail_safe_clock_recovery.sv ====
//
// Function
// - Fail-safe ends only on reset or mode entry
// - Start primary with delays, run internal meanwhile
// - On ready switch core, set flag, monitor
// - Control register stays at reset until mode
// - Mode entry selects control-register source, monitors it
// - Failure in mode runs internal, no switch-back
// - Interrupt disabled: stay in mode, run internal
// - Idle wake after failure runs on internal
// - Non-crystal modes monitor right after start
// - Crystal modes wait timers on internal first
// - Start-up failure never raises failure flag
// - New mode during start disables primary; it stays on when primary is the staged source
// - Sample clock is internal RC over 64
// - Latch set by clock, cleared by sample
// - Failure: flag, internal clock, watchdog reset
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "clock_recovery_defs.svh"

module fail_safe_clock_recovery
    import clock_recovery_pkg::*;
(
    // Clock and reset (ref_clk is the internal RC)
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Monitored oscillators, sampled on ref_clk
    input  wire logic        primary_clk,
    input  wire logic        secondary_clk,
    // Power management events from the core
    input  wire logic        pm_enter,
    input  wire logic        wake_sleep,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Clock control outputs
    output logic [1:0]       core_clk_sel,
    output logic             primary_osc_en,
    output logic             primary_clock_ready_flag,
    output logic             wdt_reset,
    output logic             pm_wake_req,
    output logic             irq
);

    // ======================================================================
    // Reset value of the whole state
    // ======================================================================
    localparam recov_regs_t RST_VAL = '{
        state     : st_start,
        osc_ctrl  : src_primary,
        pend_src  : src_primary,
        prim_mode : osc_mode_t'(`CFG_MODE_RST),
        mon_en    : `CFG_MON_EN_RST,
        ready     : 1'b0,
        core_sel  : src_internal,
        prim_en   : 1'b1,
        osc_cnt   : 11'(`OSC_EDGES),
        pll_cnt   : 9'(`PLL_LOCK_CYC),
        irq_flag  : 1'b0,
        irq_mask  : `IRQ_MASK_RST,
        irq       : 1'b0,
        wdt_clr   : 1'b0,
        pm_wake   : 1'b0,
        clk_q     : 1'b0,
        bus_wait  : 1'b1,
        rdata     : 32'h0000_0000
    };

    recov_regs_t st_ff;
    recov_regs_t nxt_st;

    logic mon_clk;
    logic mclk_fall;
    logic mon_active;
    logic fail_pulse;
    logic fail_evt;
    logic bus_req;
    logic bus_acc;
    logic wr_lane0;
    logic irq_w1c;
    logic pm_take;

    // ======================================================================
    // Helper functions
    // ======================================================================
    // Crystal and resonator modes need the start-up timer
    function automatic logic is_crystal(input osc_mode_t mode);
        is_crystal = (mode == low_power_crystal_mode) ||
                     (mode == standard_crystal_mode) ||
                     (mode == high_speed_crystal_mode) ||
                     (mode == high_speed_crystal_with_pll);
    endfunction

    // The unused source code is folded onto the internal clock
    function automatic clk_src_t to_src(input logic [1:0] code);
        to_src = (code == 2'b11) ? src_internal : clk_src_t'(code);
    endfunction

    // Register read mux; unmapped offsets read as zero
    function automatic logic [31:0] read_word(input logic [4:0]  addr,
                                              input recov_regs_t r);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (addr)
            `REG_OSC_CTRL: begin
                w[`CTRL_SRC_LSB +: 2]  = r.osc_ctrl;
                w[`CTRL_PEND_LSB +: 2] = r.pend_src;
            end
            `REG_OSC_CFG: begin
                w[`CFG_MODE_LSB +: 3]  = r.prim_mode;
                w[`CFG_MON_EN_BIT]     = r.mon_en;
            end
            `REG_STATUS: begin
                w[`STAT_READY_BIT]     = r.ready;
                w[`STAT_FAILSAFE_BIT]  = (r.state == st_failsafe);
                w[`STAT_CORE_LSB +: 2] = r.core_sel;
                w[`STAT_PRIM_EN_BIT]   = r.prim_en;
                w[`STAT_STATE_LSB +: 2] = r.state;
            end
            `REG_IRQ_STAT: w[`IRQ_OSC_FAIL_BIT] = r.irq_flag;
            `REG_IRQ_MASK: w[`IRQ_OSC_FAIL_BIT] = r.irq_mask;
            default:       w = 32'h0000_0000;
        endcase
        read_word = w;
    endfunction

    // ======================================================================
    // Monitored clock edge and sample monitor
    // ======================================================================
    // Watch the secondary in a mode that selects it, the primary in every other state
    assign mon_clk   = (st_ff.state == st_pm && st_ff.osc_ctrl == src_secondary) ?
                       secondary_clk : primary_clk;
    assign mclk_fall = st_ff.clk_q & ~mon_clk;

    // Start-up never monitors, so a dead crystal cannot flag a failure
    assign mon_active = st_ff.mon_en &&
                        ((st_ff.state == st_primary) ||
                         (st_ff.state == st_pm &&
                          st_ff.osc_ctrl != src_internal));

    sample_clock_monitor u_monitor (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .mon_en     (mon_active),
        .mclk_fall  (mclk_fall),
        .fail_pulse (fail_pulse)
    );

    // A late result is dropped if monitoring stopped meanwhile
    assign fail_evt = fail_pulse && mon_active;

    // ======================================================================
    // Bus decode
    // ======================================================================
    // One wait cycle per access keeps read data registered
    assign bus_req  = avs_read || avs_write;
    assign bus_acc  = bus_req && !st_ff.bus_wait;
    assign wr_lane0 = bus_acc && avs_write && avs_byteenable[0];
    assign irq_w1c  = wr_lane0 && (avs_address == `REG_IRQ_STAT) &&
                      avs_writedata[`IRQ_OSC_FAIL_BIT];

    // Mode entry is taken unless a failure, or a wake while in a managed mode, wins the same cycle
    assign pm_take  = pm_enter && !fail_evt &&
                      !(st_ff.state == st_pm && wake_sleep);

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.wdt_clr = 1'b0;
        nxt_st.pm_wake = 1'b0;
        nxt_st.clk_q   = mon_clk;

        // Avalon handshake and readback
        nxt_st.bus_wait = !(bus_req && st_ff.bus_wait);
        if (bus_req && st_ff.bus_wait) begin
            nxt_st.rdata = read_word(avs_address, st_ff);
        end

        // Register writes; control writes only stage the source
        if (wr_lane0) begin
            case (avs_address)
                `REG_OSC_CTRL: nxt_st.pend_src = to_src(avs_writedata[`CTRL_SRC_LSB +: 2]);
                `REG_OSC_CFG: begin
                    nxt_st.prim_mode = osc_mode_t'(avs_writedata[`CFG_MODE_LSB +: 3]);
                    nxt_st.mon_en    = avs_writedata[`CFG_MON_EN_BIT];
                end
                `REG_IRQ_MASK: nxt_st.irq_mask = avs_writedata[`IRQ_OSC_FAIL_BIT];
                default: nxt_st.pend_src = st_ff.pend_src;
            endcase
        end

        // Controller
        unique case (st_ff.state)
            st_start: begin
                nxt_st.core_sel = src_internal;
                if (!is_crystal(st_ff.prim_mode)) begin
                    nxt_st.ready    = 1'b1;
                    nxt_st.core_sel = src_primary;
                    nxt_st.state    = st_primary;
                end else if (st_ff.osc_cnt != 11'h000) begin
                    if (mclk_fall) begin
                        nxt_st.osc_cnt = 11'(st_ff.osc_cnt - 11'h001);
                    end
                end else if (st_ff.prim_mode == high_speed_crystal_with_pll &&
                             st_ff.pll_cnt != 9'h000) begin
                    nxt_st.pll_cnt = 9'(st_ff.pll_cnt - 9'h001);
                end else begin
                    nxt_st.ready    = 1'b1;
                    nxt_st.core_sel = src_primary;
                    nxt_st.state    = st_primary;
                end
            end
            st_primary, st_pm: begin
                if (fail_evt) begin
                    // Control register is left alone: that is the fail-safe mark
                    nxt_st.state    = st_failsafe;
                    nxt_st.core_sel = src_internal;
                    nxt_st.wdt_clr  = 1'b1;
                    nxt_st.pm_wake  = (st_ff.state == st_pm) &&
                                      st_ff.irq_mask;
                end else if (st_ff.state == st_pm && wake_sleep) begin
                    // Sleep exit restarts the primary like a power-on
                    nxt_st.state    = st_start;
                    nxt_st.core_sel = src_internal;
                    nxt_st.prim_en  = 1'b1;
                    nxt_st.ready    = 1'b0;
                    nxt_st.osc_cnt  = 11'(`OSC_EDGES);
                    nxt_st.pll_cnt  = 9'(`PLL_LOCK_CYC);
                end
            end
            st_failsafe: begin
                // Stays on the internal clock, no automatic return
                nxt_st.core_sel = src_internal;
            end
        endcase

        // Power managed mode entry
        if (pm_take) begin
            nxt_st.state    = st_pm;
            nxt_st.osc_ctrl = st_ff.pend_src;
            nxt_st.core_sel = st_ff.pend_src;
            nxt_st.prim_en  = (st_ff.pend_src == src_primary);
            nxt_st.ready    = st_ff.ready && (st_ff.pend_src == src_primary) &&
                              (st_ff.state != st_failsafe);
        end

        // Sticky failure flag, a new event beats the clear
        nxt_st.irq_flag = (st_ff.irq_flag && !irq_w1c) || fail_evt;
        nxt_st.irq      = nxt_st.irq_flag && nxt_st.irq_mask;
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= RST_VAL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flops
    assign avs_readdata             = st_ff.rdata;
    assign avs_waitrequest          = st_ff.bus_wait;
    assign core_clk_sel             = st_ff.core_sel;
    assign primary_osc_en           = st_ff.prim_en;
    assign primary_clock_ready_flag = st_ff.ready;
    assign wdt_reset                = st_ff.wdt_clr;
    assign pm_wake_req              = st_ff.pm_wake;
    assign irq                      = st_ff.irq;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_fail_actions;
        fail_evt |=> (core_clk_sel == src_internal) && wdt_reset &&
                     st_ff.irq_flag && (st_ff.state == st_failsafe);
    endproperty
    a_fail_actions: assert property (p_fail_actions)
        else $error("failure did not switch clock, flag and reset watchdog");

    property p_failsafe_hold;
        (st_ff.state == st_failsafe && !pm_enter) |=>
            (st_ff.state == st_failsafe) && (core_clk_sel == src_internal);
    endproperty
    a_failsafe_hold: assert property (p_failsafe_hold)
        else $error("fail-safe left without mode entry");

    property p_ready_switch;
        $rose(primary_clock_ready_flag) |->
            (core_clk_sel == src_primary) && $past(st_ff.state == st_start);
    endproperty
    a_ready_switch: assert property (p_ready_switch)
        else $error("ready flag rose without switch to primary");

    property p_start_internal;
        (st_ff.state == st_start) |-> (core_clk_sel == src_internal) && !fail_evt;
    endproperty
    a_start_internal: assert property (p_start_internal)
        else $error("start-up not on internal clock or flagged failure");

    property p_start_ctrl_hold;
        (st_ff.state == st_start && $past(st_ff.state) == st_start) |->
            $stable(st_ff.osc_ctrl);
    endproperty
    a_start_ctrl_hold: assert property (p_start_ctrl_hold)
        else $error("control register changed during start-up");

    property p_pm_select;
        pm_take |=> (st_ff.state == st_pm) && (core_clk_sel == $past(st_ff.pend_src)) &&
                    (st_ff.osc_ctrl == $past(st_ff.pend_src));
    endproperty
    a_pm_select: assert property (p_pm_select)
        else $error("mode entry did not select staged source");

    property p_pm_fail_wake;
        (fail_evt && st_ff.state == st_pm) |=> (pm_wake_req == $past(st_ff.irq_mask));
    endproperty
    a_pm_fail_wake: assert property (p_pm_fail_wake)
        else $error("mode exit on failure does not follow mask");

    property p_start_pm_prim_off;
        (pm_take && st_ff.state == st_start && st_ff.pend_src != src_primary) |=>
            !primary_osc_en;
    endproperty
    a_start_pm_prim_off: assert property (p_start_pm_prim_off)
        else $error("primary left running after new mode in start-up");

    property p_flag_sticky;
        (st_ff.irq_flag && !irq_w1c) |=> st_ff.irq_flag && (irq == st_ff.irq_mask);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("failure flag lost without a clear");

    c_startup_done: cover property ($rose(primary_clock_ready_flag));
    c_run_fail:     cover property (st_ff.state == st_primary ##1 fail_evt);
    c_pm_fail_wake: cover property (fail_evt && st_ff.state == st_pm ##1 pm_wake_req);
    c_recover:      cover property (st_ff.state == st_failsafe ##1 st_ff.state == st_pm);

endmodule // fail_safe_clock_recovery

// ==== rtl/sample_clock_monitor.sv ====
`timescale 1ns/1ps
`include "clock_recovery_defs.svh"

module sample_clock_monitor
    import clock_recovery_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Monitor control
    input  wire logic mon_en,
    input  wire logic mclk_fall,
    // Result
    output logic      fail_pulse
);

    monitor_regs_t mon_ff;
    monitor_regs_t nxt_mon;
    logic          sample_rise;
    logic          sample_fall;

    // Sample clock phases taken from the divider count
    assign sample_rise = (mon_ff.div == 6'h00);
    assign sample_fall = (mon_ff.div == 6'(`SAMPLE_HALF));
    assign fail_pulse  = mon_ff.fail;

    // ======================================================================
    // Divider and clock-seen latch
    // ======================================================================
    // Held clear while idle so a stale latch cannot fire on enable
    always_comb begin
        nxt_mon      = mon_ff;
        nxt_mon.fail = 1'b0;
        if (!mon_en) begin
            nxt_mon.div   = 6'h00;
            nxt_mon.latch = 1'b0;
        end else begin
            nxt_mon.div = 6'(mon_ff.div + 6'h01);
            if (sample_rise) begin
                nxt_mon.latch = 1'b0;
            end
            if (mclk_fall) begin
                nxt_mon.latch = 1'b1;               // Set beats clear
            end
            if (sample_fall && mon_ff.latch) begin
                nxt_mon.fail = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mon_ff <= '0;
        end else begin
            mon_ff <= nxt_mon;
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    property p_fail_cause;
        @(posedge ref_clk) disable iff (rst)
        fail_pulse |-> $past(mon_ff.latch) && $past(sample_fall) && $past(mon_en);
    endproperty
    a_fail_cause: assert property (p_fail_cause)
        else $error("failure flagged without a set latch at sample fall");

    property p_div_period;
        @(posedge ref_clk) disable iff (rst)
        ($past(mon_en) && mon_en && sample_rise) |-> ($past(mon_ff.div) == 6'h3f);
    endproperty
    a_div_period: assert property (p_div_period)
        else $error("sample clock period is not sixty-four cycles");

endmodule // sample_clock_monitor
